// File: inc/serial_tx_pkg.sv
// Purpose: Shared constants and types for the asynchronous serial transmitter.
// Assumes: 250 MHz system clock; one instruction cycle is a fixed number of clocks.
// Notes:   All widths are fixed.
package serial_tx_pkg;
  localparam int          DATA_W       = 9;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          BAUD_W       = 16;
  localparam int          BAUD_LO_W    = 8;
  localparam int          TCY_CLKS     = 4;
  localparam int          BIT_IDX_W    = 4;
  localparam logic [3:0]  BITS_EIGHT   = 4'h8;
  localparam logic [3:0]  BITS_NINE    = 4'h9;
  localparam logic        LINE_MARK    = 1'b1;
  localparam logic        LINE_SPACE   = 1'b0;
  localparam logic [15:0] BAUD_RST     = 16'h0000;
  localparam logic [3:0]  FLAG_DELAY   = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b11,
    ST_STOP  = 2'b10
  } tx_state_t;

  function automatic logic [15:0] baud_reload(input logic [15:0] div, input logic wide);
    baud_reload = wide ? div : {8'h00, div[BAUD_LO_W-1:0]};
  endfunction
endpackage

// File: rtl/serial_tx_fifo.sv
// Purpose: Small valid/ready FIFO for characters.
// Assumes: Single clock, freeze on clock enable low.
// Notes:   Read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_ce,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 cnt;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } fifo_t;
  fifo_t s_reg, s_next;
  logic  push, pop, load;

  always_comb begin
    s_next = s_reg;
    load   = !s_reg.ov || i_out_ready;
    pop    = load && (s_reg.cnt != '0);
    push   = i_in_valid && (s_reg.cnt != (AW+1)'(DEPTH));
    if (push) begin
      s_next.mem[s_reg.wp] = i_in_data;
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (load) begin
      s_next.ov = pop;
      if (pop) begin
        s_next.od = s_reg.mem[s_reg.rp];
        s_next.rp = s_reg.rp + 1'b1;
      end
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (i_flush) begin
      s_next.cnt = '0;
      s_next.wp  = '0;
      s_next.rp  = '0;
      s_next.ov  = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_reg <= '0;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  assign o_in_ready  = (s_reg.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = s_reg.ov;
  assign o_out_data  = s_reg.od;
endmodule
`default_nettype wire

// File: rtl/serial_tx_baud.sv
// Purpose: Baud tick generator, 8-bit or 16-bit divider from the system clock.
// Assumes: Divider value d gives one tick every d+1 enabled clocks.
// Notes:   Restart realigns the divider to the start of a bit.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_baud
  import serial_tx_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire logic        i_restart,
  input  wire logic        i_wide,
  input  wire logic [15:0] i_div,
  output logic             o_tick
);
  typedef struct packed {
    logic [15:0] cnt;
  } baud_t;
  baud_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (i_restart || s_reg.cnt == 16'h0000) begin
      s_next.cnt = baud_reload(i_div, i_wide);
    end else begin
      s_next.cnt = s_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_reg.cnt <= BAUD_RST;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  assign o_tick = i_ce && !i_restart && (s_reg.cnt == 16'h0000);
endmodule
`default_nettype wire

// File: rtl/serial_tx.sv
// Purpose: Asynchronous NRZ serial transmitter with holding buffer and empty flag.
// Assumes: Software writes arrive as one-cycle strobes on the system clock.
// Notes:   The holding buffer is the first FIFO entry; the FIFO output register loads the shift register.
`timescale 1ns/1ps
`default_nettype none
module serial_tx
  import serial_tx_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_ce,
  input  wire logic                      i_transmit_enable_bit,
  input  wire logic                      i_serial_port_enable,
  input  wire logic                      i_sync_mode,
  input  wire logic                      i_nine_bit,
  input  wire logic                      i_two_stop,
  input  wire logic                      i_baud_wide,
  input  wire logic [15:0]               i_baud_div,
  input  wire logic                      i_holding_write,
  input  wire logic [serial_tx_pkg::DATA_W-1:0] i_holding_data,
  input  wire logic                      i_transmit_interrupt_enable,
  input  wire logic                      i_port_latch_tx,
  input  wire logic                      i_port_latch_rx,
  input  wire logic                      i_pin_dir_tx_n,
  input  wire logic                      i_pin_dir_rx_n,
  input  wire logic                      i_receive_data_pin,
  output logic                           o_transmit_clock_pin,
  output logic                           o_transmit_clock_pin_oe,
  output logic                           o_receive_data_pin,
  output logic                           o_receive_data_pin_oe,
  output logic                           o_rx_port_read,
  output logic                           o_holding_ready,
  output logic                           o_transmit_buffer_empty_flag,
  output logic                           o_irq,
  output logic                           o_busy
);
  typedef struct packed {
    tx_state_t             st;
    logic [DATA_W-1:0]     shreg;
    logic [BIT_IDX_W-1:0]  idx;
    logic                  stop2;
    logic                  line;
    logic                  flag;
    logic [3:0]            hold;
    logic                  rx_s1;
    logic                  rx_s2;
  } tx_t;
  tx_t  s_reg, s_next;

  logic active, f_valid, f_ready_out, f_in_ready, tick, restart;
  logic [DATA_W-1:0] f_data;
  logic [BIT_IDX_W-1:0] nbits;

  // ****************************************************************
  // Holding buffer and baud generator
  // ****************************************************************
  assign active  = i_transmit_enable_bit && i_serial_port_enable && !i_sync_mode;
  assign nbits   = i_nine_bit ? BITS_NINE : BITS_EIGHT;
  assign restart = (s_reg.st == ST_IDLE);

  // The shift register only ever takes the holding buffer output.
  assign f_ready_out = (s_reg.st == ST_IDLE) || ((s_reg.st == ST_STOP) && tick && !s_reg.stop2);

  serial_tx_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_ce        (i_ce),
    .i_flush     (!active),
    .i_in_valid  (i_holding_write && active),
    .o_in_ready  (f_in_ready),
    .i_in_data   (i_holding_data),
    .o_out_valid (f_valid),
    .i_out_ready (f_ready_out && active),
    .o_out_data  (f_data)
  );

  serial_tx_baud u_baud (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_ce      (i_ce),
    .i_restart (restart),
    .i_wide    (i_baud_wide),
    .i_div     (i_baud_div),
    .o_tick    (tick)
  );

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  always_comb begin
    s_next       = s_reg;
    s_next.rx_s1 = i_receive_data_pin;
    s_next.rx_s2 = s_reg.rx_s1;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.line = LINE_MARK;
        if (active && f_valid) begin
          s_next.shreg = f_data;
          s_next.st    = ST_START;
          s_next.line  = LINE_SPACE;
          s_next.idx   = '0;
        end
      end
      ST_START: begin
        if (tick) begin
          s_next.st    = ST_DATA;
          s_next.line  = s_reg.shreg[0];
          s_next.shreg = s_reg.shreg >> 1;
          s_next.idx   = 4'h1;
        end
      end
      ST_DATA: begin
        if (tick) begin
          if (s_reg.idx == nbits) begin
            s_next.st    = ST_STOP;
            s_next.line  = LINE_MARK;
            s_next.stop2 = i_two_stop;
          end else begin
            s_next.line  = s_reg.shreg[0];
            s_next.shreg = s_reg.shreg >> 1;
            s_next.idx   = s_reg.idx + 4'h1;
          end
        end
      end
      ST_STOP: begin
        if (tick) begin
          if (s_reg.stop2) begin
            s_next.stop2 = 1'b0;
          end else if (f_valid) begin
            s_next.shreg = f_data;
            s_next.st    = ST_START;
            s_next.line  = LINE_SPACE;
            s_next.idx   = '0;
          end else begin
            s_next.st = ST_IDLE;
          end
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (!active) begin
      s_next.st    = ST_IDLE;
      s_next.line  = LINE_MARK;
      s_next.stop2 = 1'b0;
    end
    // Flag holds its old value for two instruction cycles after a write.
    if (i_holding_write && active) begin
      s_next.hold = FLAG_DELAY;
    end else if (s_reg.hold != 4'h0) begin
      s_next.hold = s_reg.hold - 4'h1;
    end
    if (!i_transmit_enable_bit) begin
      s_next.flag = 1'b0;
      s_next.hold = 4'h0;
    end else if (!i_transmit_enable_bit || s_reg.hold == 4'h0 || s_next.hold == 4'h0) begin
      s_next.flag = !(f_valid && f_ready_out == 1'b0) || !active;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_reg       <= '0;
      s_reg.line  <= LINE_MARK;
      s_reg.rx_s1 <= 1'b1;
      s_reg.rx_s2 <= 1'b1;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Pins and status
  // ****************************************************************
  assign o_transmit_clock_pin    = i_serial_port_enable ? s_reg.line : i_port_latch_tx;
  assign o_transmit_clock_pin_oe = i_serial_port_enable || i_pin_dir_tx_n;
  assign o_receive_data_pin      = i_port_latch_rx;
  assign o_receive_data_pin_oe   = !i_serial_port_enable && i_pin_dir_rx_n;
  assign o_rx_port_read          = s_reg.rx_s2;
  // Ready must match what the FIFO really takes, or a refused write would still be queued.
  assign o_holding_ready         = f_in_ready && active;
  assign o_transmit_buffer_empty_flag = s_reg.flag;
  assign o_irq                   = s_reg.flag && i_transmit_interrupt_enable;
  assign o_busy                  = (s_reg.st != ST_IDLE);

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_start_bit;
    s_reg.st == ST_START && s_reg.line == LINE_SPACE;
  endsequence

  AST_IDLE_MARK: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (s_reg.st == ST_IDLE) |-> o_transmit_clock_pin == LINE_MARK || !i_serial_port_enable)
    else $error("Idle line not at mark.");
  AST_START_SPACE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (s_reg.st == ST_START) |-> s_reg.line == LINE_SPACE)
    else $error("Start bit not space.");
  AST_STOP_MARK: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (s_reg.st == ST_STOP) |-> s_reg.line == LINE_MARK)
    else $error("Stop bit not mark.");
  AST_TX_OE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_serial_port_enable |-> o_transmit_clock_pin_oe)
    else $error("Transmit pin not output.");
  AST_RX_IN: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_serial_port_enable |-> !o_receive_data_pin_oe)
    else $error("Receive pin driven.");
  AST_IRQ_GATE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_irq |-> o_transmit_buffer_empty_flag && i_transmit_interrupt_enable)
    else $error("Interrupt without flag and enable.");
  AST_LOAD_START: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && active && s_reg.st == ST_IDLE && f_valid) |=> seq_start_bit)
    else $error("Idle load did not start frame.");
  AST_DISABLE_IDLE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !active) |=> s_reg.st == ST_IDLE && s_reg.line == LINE_MARK)
    else $error("Disabled transmitter not idle.");
  AST_BIT_HOLD: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && active && s_reg.st != ST_IDLE && !tick) |=> $stable(s_reg.line))
    else $error("Line changed inside a bit period.");
  AST_DATA_LSB: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && active && s_reg.st == ST_DATA && tick && s_reg.idx != nbits) |=> s_reg.line == $past(s_reg.shreg[0]))
    else $error("Data bit not taken from the low end.");
  AST_FLAG_OFF: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_transmit_enable_bit) |=> !o_transmit_buffer_empty_flag)
    else $error("Empty flag set while transmit disabled.");
  AST_FLAG_ON: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && i_transmit_enable_bit && s_reg.hold == 4'h0 && !f_valid) |=> o_transmit_buffer_empty_flag)
    else $error("Empty flag clear with nothing queued.");
endmodule
`default_nettype wire

// File: verification/serial_line_receiver.sv
// Purpose: Remote asynchronous receiver that watches the serial line.
// Assumes: The bench gives the bit period in system clocks.
// Notes:   Samples each bit in its middle; any framing fault sets o_frame_err.
`timescale 1ns/1ps
`default_nettype none
module serial_line_receiver
  import serial_tx_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_line,
  input  wire logic        i_nine,
  input  wire logic        i_two_stop,
  input  wire logic [16:0] i_period,
  output logic [8:0]       o_data,
  output logic             o_frame_err,
  output int               o_count
);
  logic [8:0] shift;
  initial begin
    o_data = '0;
    o_frame_err = 1'h0;
    o_count = 0;
    shift = '0;
    // A port latch low before the port is enabled is no start bit.
    wait (i_line === LINE_MARK);
    forever begin
      @(negedge i_line);
      repeat (int'(i_period) / 2) @(posedge i_clk);
      if (i_line !== LINE_SPACE) o_frame_err = 1'h1;
      shift = '0;
      for (int i = 0; i < (i_nine ? 9 : 8); i++) begin
        repeat (int'(i_period)) @(posedge i_clk);
        shift[i] = i_line;
      end
      for (int s = 0; s < (i_two_stop ? 2 : 1); s++) begin
        repeat (int'(i_period)) @(posedge i_clk);
        if (i_line !== LINE_MARK) o_frame_err = 1'h1;
      end
      o_data = shift;
      o_count = o_count + 1;
    end
  end
endmodule
`default_nettype wire

// File: verification/serial_tx_test.sv
// Purpose: Self-checking bench for the serial transmitter.
// Assumes: Receiver model decodes the line at the configured period.
// Notes:   Frame spacing is measured in clocks between received characters.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_test;
  import serial_tx_pkg::*;
  logic clk = 1'h0, arst_n = 1'h0, transmit_enable_bit = 1'h0, serial_port_enable = 1'h0, nine = 1'h0, two = 1'h0, wide = 1'h0;
  logic wr = 1'h0, ie = 1'h0, lat_tx = 1'h0, lat_rx = 1'h1, dir_tx_n = 1'h0, dir_rx_n = 1'h1, rx_pin = 1'h1;
  logic [15:0] div = 16'h0007;
  logic [8:0]  wd = 9'h000, rx_data;
  logic [16:0] period = 17'h00008;
  logic tx_pin, tx_oe, rx_out, rx_oe, rx_read, ready, flag, irq, busy, rx_err;
  int fail_count = 0, total_checks = 0, cyc = 0, rx_count;
  // ****************************************
  // Clock, models and helpers
  // ****************************************
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  serial_tx u_serial_tx (.i_clk(clk), .i_arst_n(arst_n), .i_ce(1'h1), .i_transmit_enable_bit(transmit_enable_bit),
    .i_serial_port_enable(serial_port_enable), .i_sync_mode(1'h0), .i_nine_bit(nine), .i_two_stop(two), .i_baud_wide(wide),
    .i_baud_div(div), .i_holding_write(wr), .i_holding_data(wd), .i_transmit_interrupt_enable(ie),
    .i_port_latch_tx(lat_tx), .i_port_latch_rx(lat_rx), .i_pin_dir_tx_n(dir_tx_n), .i_pin_dir_rx_n(dir_rx_n),
    .i_receive_data_pin(rx_pin), .o_transmit_clock_pin(tx_pin), .o_transmit_clock_pin_oe(tx_oe),
    .o_receive_data_pin(rx_out), .o_receive_data_pin_oe(rx_oe), .o_rx_port_read(rx_read),
    .o_holding_ready(ready), .o_transmit_buffer_empty_flag(flag), .o_irq(irq), .o_busy(busy));
  serial_line_receiver u_serial_line_receiver (.i_clk(clk), .i_line(tx_pin), .i_nine(nine), .i_two_stop(two),
    .i_period(period), .o_data(rx_data), .o_frame_err(rx_err), .o_count(rx_count));
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic at_neg(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [8:0] pat(input int i);
    pat = 9'h1A5 ^ (9'(i) * 9'h033);
  endfunction
  task automatic wait_rx(input logic [8:0] exp, output int at);
    int start;
    start = rx_count;
    for (int i = 0; i < 4000 && rx_count == start; i++) @(negedge clk);
    if (rx_count == start) begin
      fail_count++;
      close_out();
    end
    at = cyc;
    check(rx_data, exp, "received character");
  endtask
  // Burst of up to n writes held back to back until the buffer refuses, then frame-by-frame receipt.
  task automatic run(input int n, input int fbits);
    int acc, t0, t1;
    logic [8:0] want;
    acc = 0;
    for (int i = 0; i < n && acc == i; i++) begin
      @(posedge clk);
      wr <= 1'h1;
      wd <= pat(i);
      @(negedge clk);
      if (ready === 1'h1) acc++;
    end
    @(posedge clk);
    wr <= 1'h0;
    // The FIFO words, its output register and the shift register all fill before a refusal.
    check(16'(acc), 16'(n < FIFO_DEPTH + 2 ? n : FIFO_DEPTH + 2), "accepted before refusal");
    if (n > 1) begin
      at_neg(10);
      check(flag, 1'h0, "flag with character queued");
      check(irq, 1'h0, "irq with flag clear");
    end
    for (int i = 0; i < acc; i++) begin
      want = pat(i);
      wait_rx(nine ? want : {1'h0, want[7:0]}, t1);
      if (i > 0) check(16'(t1 - t0), 16'(fbits * int'(period)), "frame spacing");
      t0 = t1;
    end
    at_neg(int'(period));
    check(busy, 1'h0, "busy after last stop");
    check(tx_pin, LINE_MARK, "idle line");
    check(flag, 1'h1, "flag with buffer empty");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int snap;
    at_neg(12);
    @(posedge clk);
    arst_n <= 1'h1;
    at_neg(2);
    check(tx_pin, 1'h0, "tx pin from port latch while port off");
    check(flag, 1'h0, "flag while disabled");
    check(ready, 1'h0, "write refused while disabled");
    check(rx_oe, 1'h1, "rx pin enable from direction bit");
    check(rx_out, 1'h1, "rx pin from port latch");
    check(tx_oe, 1'h0, "tx pin enable from direction bit");
    $display("test reset done");
    @(posedge clk);
    serial_port_enable <= 1'h1;
    transmit_enable_bit <= 1'h1;
    rx_pin <= 1'h0;
    at_neg(4);
    check(tx_pin, LINE_MARK, "idle line on enable");
    check(tx_oe, 1'h1, "tx pin forced to output");
    check(rx_oe, 1'h0, "rx pin forced to input");
    check(rx_read, 1'h0, "rx pin readable");
    check(flag, 1'h1, "flag on enable");
    check(irq, 1'h0, "irq masked");
    @(posedge clk);
    ie <= 1'h1;
    at_neg(1);
    check(irq, 1'h1, "irq with flag and enable");
    $display("test enable done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      wide <= (i == 1);
      div <= (i == 2) ? 16'h0003 : 16'h0107;
      nine <= (i == 2);
      two <= (i == 2);
      period <= (i == 0) ? 17'h00008 : (i == 1) ? 17'h00108 : 17'h00004;
      run(i == 2 ? 8 : 2, i == 2 ? 12 : 10);
      $display("test baud setting %0d done", i);
    end
    @(posedge clk);
    ie <= 1'h0;
    nine <= 1'h0;
    two <= 1'h0;
    div <= 16'h0007;
    period <= 17'h00008;
    wr <= 1'h1;
    wd <= 9'h055;
    @(posedge clk);
    wd <= 9'h0AA;
    @(posedge clk);
    wr <= 1'h0;
    repeat (20) @(posedge clk);
    transmit_enable_bit <= 1'h0;
    at_neg(2);
    check(tx_pin, LINE_MARK, "line after abort");
    check(busy, 1'h0, "busy after abort");
    check(irq, 1'h0, "irq off");
    at_neg(120);
    snap = rx_count;
    @(posedge clk);
    transmit_enable_bit <= 1'h1;
    at_neg(200);
    check(16'(rx_count - snap), 16'h0000, "nothing sent after re-enable");
    check(flag, 1'h1, "flag after re-enable");
    check(rx_err, 1'h0, "framing");
    $display("test abort done");
    close_out();
  end
endmodule
`default_nettype wire
